// file: logic/wot_cfg.svh
// Constants of the wake-on-radio event timer: offsets, resets, counts.
// Assumes inclusion by bare name from the package and the modules.
//
// Operation
// - Event 0 time: 750 crystal periods x timeout, x 32 when resolution bit 0 is set.
// - Timeout high byte has its own register, reset 0x87; low byte follows.
// - Slow timing clock is crystal clock divided by 750.
// - Slow oscillator power-down resets to 1; clearing it calibrates.
// - Event 1 follows Event 0 after 4..48 slow periods; the timer always passes sync as 0.
// - Calibration enable resets to 1; clearing it blocks calibration.
// - Resolution 00 gives one period per count, 01 gives 32 periods.
// - Resolution setting does not change the time readout resolution.
`ifndef WOT_CFG_SVH
`define WOT_CFG_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define WOT_OFF_TMO_HI 6'h1E
`define WOT_OFF_TMO_LO 6'h1F
`define WOT_OFF_CTRL 6'h20
// ----------------------------------------------------------------
// Field positions of the wake control register
// ----------------------------------------------------------------
`define WOT_CTRL_PD_BIT 7
`define WOT_CTRL_EV1_HI 6
`define WOT_CTRL_EV1_LO 4
`define WOT_CTRL_CAL_BIT 3
`define WOT_CTRL_RES_HI 1
`define WOT_CTRL_RES_LO 0
`define WOT_CTRL_MASK 8'hFB
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WOT_RST_TMO_HI 8'h87
`define WOT_RST_TMO_LO 8'h6B
`define WOT_RST_PD 1'b1
`define WOT_RST_EV1 3'h7
`define WOT_RST_CAL 1'b1
`define WOT_RST_RES 2'h0
// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define WOT_SLOW_DIV 750
`define WOT_RES1_PERIODS 32
`define WOT_CAL_TICKS 16
`endif

// file: logic/wot_pkg.sv
// Types and helpers of the wake-on-radio event timer.
// Assumes the constants header is on the include path.
`include "wot_cfg.svh"
package wot_pkg;
  // ----------------------------------------------------------------
  // Calibration state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    WOT_CAL_IDLE = 1'b0,
    WOT_CAL_RUN = 1'b1
  } wot_cal_state_t;

  // Event 1 delay in slow periods from the 3-bit code and sync option
  function automatic logic [7:0] wot_ev1_periods(input logic [2:0] sel,
                                                 input logic sync);
    logic [7:0] base;
    base = 8'h00;
    case (sel)
      3'h0: base = 8'h04;
      3'h1: base = 8'h06;
      3'h2: base = 8'h08;
      3'h3: base = 8'h0C;
      3'h4: base = 8'h10;
      3'h5: base = 8'h18;
      3'h6: base = 8'h20;
      default: base = 8'h30;
    endcase
    return sync ? {base[5:0], 2'b00} : base;
  endfunction : wot_ev1_periods
endpackage : wot_pkg

// file: logic/wot_slow_if.sv
// Carrier between the timer core and its slow clock divider.
// Assumes both ends sit on mclk.
`timescale 1ns/100ps
interface wot_slow_if;
  logic run;
  logic tick;
  modport div (input run, output tick);
  modport user (output run, input tick);
endinterface : wot_slow_if

// file: logic/wot_slow_div.sv
// Slow timing clock: one-cycle enable every DIV crystal cycles.
// Assumes mclk is the crystal clock; run low holds it stopped.
`timescale 1ns/100ps
`include "wot_cfg.svh"
module wot_slow_div
  import wot_pkg::*;
#(
  parameter int DIV = `WOT_SLOW_DIV
) (
  input wire logic mclk,
  input wire logic resetn,
  wot_slow_if.div slow
);
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic tick_q;
  logic tick_d;

  // Divide by DIV while running, restart from zero when stopped
  always_comb begin
    cnt_d = 10'h000;
    tick_d = 1'b0;
    if (slow.run) begin
      if (cnt_q == 10'(DIV - 1)) begin
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 10'h001;
      end
    end
  end

  // Divider state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 10'h000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign slow.tick = tick_q;
endmodule : wot_slow_div

// file: logic/wot_timer.sv
// Wake-on-radio event timer: registers, Event 0 and Event 1 timing,
// slow oscillator power-down and calibration, free time readout.
// Assumes the register port is driven synchronously to mclk.
`timescale 1ns/100ps
`include "wot_cfg.svh"
module wot_timer
  import wot_pkg::*;
#(
  parameter int CAL_TICKS = `WOT_CAL_TICKS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic wake_timeout_count_pulse,
  output logic secondary_delay_sel_pulse,
  output logic [15:0] wake_time_readout,
  output logic slow_osc_running,
  output logic cal_busy
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] tmo_hi_q, tmo_hi_d;
  logic [7:0] tmo_lo_q, tmo_lo_d;
  logic pd_q, pd_d;
  logic [2:0] ev1_sel_q, ev1_sel_d;
  logic cal_en_q, cal_en_d;
  logic [1:0] res_q, res_d;
  logic [7:0] rdata_q, rdata_d;
  wot_cal_state_t cal_st_q, cal_st_d;
  logic [7:0] cal_cnt_q, cal_cnt_d;
  logic [4:0] pre_q, pre_d;
  logic [15:0] ev0_cnt_q, ev0_cnt_d;
  logic [7:0] ev1_cnt_q, ev1_cnt_d;
  logic ev1_act_q, ev1_act_d;
  logic ev0_q, ev0_d;
  logic ev1_q, ev1_d;
  logic [15:0] time_q, time_d;
  logic run_q, run_d;
  logic tick;
  logic unit;
  logic wr_ctrl;
  logic [15:0] timeout;

  wot_slow_if slow_bus();

  // ----------------------------------------------------------------
  // Slow clock divider
  // ----------------------------------------------------------------
  wot_slow_div #(
    .DIV(`WOT_SLOW_DIV)
  ) u_div (
    .mclk(mclk),
    .resetn(resetn),
    .slow(slow_bus)
  );

  assign slow_bus.run = run_q;
  assign tick = slow_bus.tick;
  assign timeout = {tmo_hi_q, tmo_lo_q};
  assign wr_ctrl = reg_wr && (reg_addr == `WOT_OFF_CTRL);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Writes store fields; reads return a registered byte
  always_comb begin
    tmo_hi_d = tmo_hi_q;
    tmo_lo_d = tmo_lo_q;
    pd_d = pd_q;
    ev1_sel_d = ev1_sel_q;
    cal_en_d = cal_en_q;
    res_d = res_q;
    rdata_d = rdata_q;
    if (reg_wr) begin
      case (reg_addr)
        `WOT_OFF_TMO_HI: tmo_hi_d = reg_wdata;
        `WOT_OFF_TMO_LO: tmo_lo_d = reg_wdata;
        `WOT_OFF_CTRL: begin
          pd_d = reg_wdata[`WOT_CTRL_PD_BIT];
          ev1_sel_d = reg_wdata[`WOT_CTRL_EV1_HI:`WOT_CTRL_EV1_LO];
          cal_en_d = reg_wdata[`WOT_CTRL_CAL_BIT];
          res_d = reg_wdata[`WOT_CTRL_RES_HI:`WOT_CTRL_RES_LO];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `WOT_OFF_TMO_HI: rdata_d = tmo_hi_q;
        `WOT_OFF_TMO_LO: rdata_d = tmo_lo_q;
        `WOT_OFF_CTRL: begin
          rdata_d = {pd_q, ev1_sel_q, cal_en_q, 1'b0, res_q}
                    & `WOT_CTRL_MASK;
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tmo_hi_q <= `WOT_RST_TMO_HI;
      tmo_lo_q <= `WOT_RST_TMO_LO;
      pd_q <= `WOT_RST_PD;
      ev1_sel_q <= `WOT_RST_EV1;
      cal_en_q <= `WOT_RST_CAL;
      res_q <= `WOT_RST_RES;
      rdata_q <= 8'h00;
    end else begin
      tmo_hi_q <= tmo_hi_d;
      tmo_lo_q <= tmo_lo_d;
      pd_q <= pd_d;
      ev1_sel_q <= ev1_sel_d;
      cal_en_q <= cal_en_d;
      res_q <= res_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator power and calibration
  // ----------------------------------------------------------------
  // Clearing power-down from 1 starts calibration when it is enabled
  always_comb begin
    run_d = ~pd_d;
    cal_st_d = cal_st_q;
    cal_cnt_d = cal_cnt_q;
    case (cal_st_q)
      WOT_CAL_IDLE: begin
        if (wr_ctrl && pd_q && !reg_wdata[`WOT_CTRL_PD_BIT]
            && reg_wdata[`WOT_CTRL_CAL_BIT]) begin
          cal_st_d = WOT_CAL_RUN;
          cal_cnt_d = 8'(CAL_TICKS);
        end
      end
      WOT_CAL_RUN: begin
        if (pd_q || !cal_en_q) begin
          cal_st_d = WOT_CAL_IDLE;
          cal_cnt_d = 8'h00;
        end else if (tick) begin
          if (cal_cnt_q <= 8'h01) begin
            cal_st_d = WOT_CAL_IDLE;
            cal_cnt_d = 8'h00;
          end else begin
            cal_cnt_d = cal_cnt_q - 8'h01;
          end
        end
      end
      default: begin
        cal_st_d = WOT_CAL_IDLE;
        cal_cnt_d = 8'h00;
      end
    endcase
  end

  // Power and calibration state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      run_q <= 1'b0;
      cal_st_q <= WOT_CAL_IDLE;
      cal_cnt_q <= 8'h00;
    end else begin
      run_q <= run_d;
      cal_st_q <= cal_st_d;
      cal_cnt_q <= cal_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Event timing
  // ----------------------------------------------------------------
  // One Event 0 unit is one slow tick, or 32 ticks at resolution 01
  assign unit = tick && (!res_q[0]
                || pre_q == 5'(`WOT_RES1_PERIODS - 1));

  // Event 0 reload, Event 1 delay and free readout counter
  always_comb begin
    pre_d = pre_q;
    ev0_cnt_d = ev0_cnt_q;
    ev1_cnt_d = ev1_cnt_q;
    ev1_act_d = ev1_act_q;
    ev0_d = 1'b0;
    ev1_d = 1'b0;
    time_d = time_q;
    if (!run_q) begin
      pre_d = 5'h00;
      ev0_cnt_d = timeout;
      ev1_act_d = 1'b0;
      ev1_cnt_d = 8'h00;
    end else if (tick) begin
      time_d = time_q + 16'h0001;
      pre_d = res_q[0] ? pre_q + 5'h01 : 5'h00;
      if (ev1_act_q) begin
        if (ev1_cnt_q <= 8'h01) begin
          ev1_d = 1'b1;
          ev1_act_d = 1'b0;
        end else begin
          ev1_cnt_d = ev1_cnt_q - 8'h01;
        end
      end
      if (unit) begin
        if (ev0_cnt_q <= 16'h0001) begin
          ev0_d = 1'b1;
          ev0_cnt_d = timeout;
          ev1_act_d = 1'b1;
          ev1_cnt_d = wot_ev1_periods(ev1_sel_q, 1'b0);
        end else begin
          ev0_cnt_d = ev0_cnt_q - 16'h0001;
        end
      end
    end
  end

  // Event timing state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 5'h00;
      ev0_cnt_q <= 16'h0000;
      ev1_cnt_q <= 8'h00;
      ev1_act_q <= 1'b0;
      ev0_q <= 1'b0;
      ev1_q <= 1'b0;
      time_q <= 16'h0000;
    end else begin
      pre_q <= pre_d;
      ev0_cnt_q <= ev0_cnt_d;
      ev1_cnt_q <= ev1_cnt_d;
      ev1_act_q <= ev1_act_d;
      ev0_q <= ev0_d;
      ev1_q <= ev1_d;
      time_q <= time_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_q;
  assign wake_timeout_count_pulse = ev0_q;
  assign secondary_delay_sel_pulse = ev1_q;
  assign wake_time_readout = time_q;
  assign slow_osc_running = run_q;
  assign cal_busy = (cal_st_q == WOT_CAL_RUN);
endmodule : wot_timer

// file: verif/wot_timer_props.sv
// Port checker of the wake timer: reads, power-up, ticks, events.
// Assumes it is bound onto wot_timer, one clock domain.
`timescale 1ns/100ps
`include "wot_cfg.svh"
module wot_timer_props
  import wot_pkg::*;
#(
  parameter int CAL_TICKS = `WOT_CAL_TICKS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic wake_timeout_count_pulse,
  input wire logic secondary_delay_sel_pulse,
  input wire logic [15:0] wake_time_readout,
  input wire logic slow_osc_running,
  input wire logic cal_busy
);
  // ------------------------------
  // Helper state
  // ------------------------------
  localparam logic [7:0] N_TAB [8] = '{8'h04, 8'h06, 8'h08, 8'h0C,
    8'h10, 8'h18, 8'h20, 8'h30};
  logic [15:0] gap_q, gap_d, rd_q, r0_q, r0_d;
  logic seen_q, seen_d, chg, wr_ctrl;
  logic [2:0] sel_q, sel_d;
  assign chg = wake_time_readout != rd_q;
  assign wr_ctrl = reg_wr && reg_addr == 6'h20;
  // Tick spacing, delay code, readout seen at Event 0
  always_comb begin
    gap_d = chg ? 16'h0000 : gap_q + 16'h0001;
    seen_d = slow_osc_running && (seen_q || chg);
    sel_d = wr_ctrl ? reg_wdata[6:4] : sel_q;
    r0_d = wake_timeout_count_pulse ? wake_time_readout : r0_q;
  end
  // Registers of the helper state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gap_q <= 16'h0000;
      rd_q <= 16'h0000;
      r0_q <= 16'h0000;
      seen_q <= 1'b0;
      sel_q <= 3'h7;
    end else begin
      gap_q <= gap_d;
      rd_q <= wake_time_readout;
      r0_q <= r0_d;
      seen_q <= seen_d;
      sel_q <= sel_d;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_rsv;
    reg_rd && reg_addr == 6'h20 |=> !reg_rdata[2];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit");
  property p_unmap;
    reg_rd && reg_addr > 6'h20 |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_pwrup;
    wr_ctrl && !reg_wdata[7] |=> ##1 slow_osc_running;
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("no power");
  // Powering down ends any calibration in progress
  property p_cal;
    wr_ctrl && reg_wdata[7] ##1 !wr_ctrl |=> !cal_busy;
  endproperty
  a_cal: assert property (p_cal) else $error("cal kept");
  property p_calgo;
    wr_ctrl && reg_wdata[7:3] == {1'b0, sel_d, 1'b1} && !slow_osc_running
      && !$past(slow_osc_running) |=> ##1 cal_busy;
  endproperty
  a_calgo: assert property (p_calgo) else $error("no cal");
  property p_calblk;
    wr_ctrl && !reg_wdata[3] |=> ##1 !cal_busy;
  endproperty
  a_calblk: assert property (p_calblk) else $error("cal on");
  property p_tick;
    chg && seen_q |-> gap_q == 16'h02ED;
  endproperty
  a_tick: assert property (p_tick) else $error("tick gap");
  property p_ev0;
    wake_timeout_count_pulse |-> chg ##1 !wake_timeout_count_pulse;
  endproperty
  a_ev0: assert property (p_ev0) else $error("event 0");
  property p_ev1;
    secondary_delay_sel_pulse |-> 16'(wake_time_readout - r0_q) == {8'h00, N_TAB[sel_q]};
  endproperty
  a_ev1: assert property (p_ev1) else $error("event 1");
  c_ev0: cover property (wake_timeout_count_pulse);
  c_ev1: cover property (secondary_delay_sel_pulse);
  c_cal: cover property ($rose(cal_busy));
endmodule : wot_timer_props
bind wot_timer wot_timer_props #(.CAL_TICKS(CAL_TICKS)) wot_timer_props_i (
  .mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .wake_timeout_count_pulse, .secondary_delay_sel_pulse, .wake_time_readout, .slow_osc_running,
  .cal_busy);

// file: verif/wot_timer_bench.sv
// Self-checking bench of the wake timer: registers, events, power.
// Assumes design files and checker are compiled before it.
`timescale 1ns/100ps
module wot_timer_bench;
  import wot_pkg::*;
  localparam logic [7:0] N_TAB [8] = '{8'h04, 8'h06, 8'h08, 8'h0C,
    8'h10, 8'h18, 8'h20, 8'h30};
  logic mclk, resetn, reg_wr, reg_rd, wake_timeout_count_pulse, secondary_delay_sel_pulse;
  logic slow_osc_running, cal_busy;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [15:0] wake_time_readout, r, r2;
  logic [31:0] lfsr;
  int failures, comparisons;
  wot_timer #(.CAL_TICKS(2)) wot_timer_i (.mclk, .resetn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wake_timeout_count_pulse, .secondary_delay_sel_pulse,
    .wake_time_readout, .slow_osc_running, .cal_busy);
  // Clock of 10 ns
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // Control read-back drops the reserved bit
  function automatic logic [7:0] ctrl_rb(input logic [7:0] d);
    return d & 8'hFB;
  endfunction : ctrl_rb
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    check(reg_rdata, e);
  endtask : rd
  // Wait for an event pulse, then take the readout
  task automatic wait_ev(input logic one, output logic [15:0] rv);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 30000 && !hit; n++) begin
      @(posedge mclk);
      #1;
      hit = one ? secondary_delay_sel_pulse : wake_timeout_count_pulse;
    end
    check(hit, 1'b1);
    rv = wake_time_readout;
  endtask : wait_ev
  task automatic test_done;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  // Watchdog
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    test_done();
  end
  // Main sequence
  initial begin
    failures = 0;
    comparisons = 0;
    lfsr = 32'hC02544D9;
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    repeat (2) @(posedge mclk);
    #1;
    resetn = 1'b1;
    rd(6'h1E, 8'h87);
    rd(6'h1F, 8'h6B);
    rd(6'h20, 8'hF8);
    check(slow_osc_running, 1'b0);
    rd(6'h21, 8'h00);
    // Random writes read back while powered down
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      v = {1'b1, lfsr[22:18], 1'b0, lfsr[16]};
      wr(6'h1E, lfsr[7:0]);
      wr(6'h1F, lfsr[15:8]);
      wr(6'h20, v);
      rd(6'h1E, lfsr[7:0]);
      rd(6'h1F, lfsr[15:8]);
      rd(6'h20, ctrl_rb(v));
      rd(lfsr[29:24] > 6'h20 ? lfsr[29:24] : 6'h3F, 8'h00);
    end
    // Timeout 13 at resolution 00, delay codes 0 to 3
    wr(6'h1E, 8'h00);
    wr(6'h1F, 8'h0D);
    wr(6'h20, 8'h08);
    @(posedge mclk);
    #1;
    check(slow_osc_running, 1'b1);
    check(cal_busy, 1'b1);
    wait_ev(1'b0, r);
    for (int s = 0; s < 4; s++) begin
      wait_ev(1'b1, r2);
      check(r2 - r, {8'h00, N_TAB[s]});
      wr(6'h20, {1'b0, 3'(s + 1), 4'h8});
      wait_ev(1'b0, r2);
      check(r2 - r, 16'h000D);
      r = r2;
    end
    // Power-down holds the readout; then timeout 1 at resolution 01
    wr(6'h20, 8'h80);
    repeat (2) @(posedge mclk);
    #1;
    r = wake_time_readout;
    repeat (800) @(posedge mclk);
    #1;
    check(wake_time_readout, r);
    wr(6'h1F, 8'h01);
    wr(6'h20, 8'h01);
    @(posedge mclk);
    #1;
    check(cal_busy, 1'b0);
    wait_ev(1'b0, r2);
    check(r2 - r, 16'h0020);
    test_done();
  end
endmodule : wot_timer_bench
